/* File: verilog/fnb_top.sv */
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Eight lock bits, each guarding a region of 32 pages of 128 bytes.
// - Program or erase into a locked region is dropped and raises interrupt.
// - Software set-lock and clear-lock commands change one region's lock bit.
// - Wipe pin clears all lock bits, unlocking the whole flash.
// - Security bit set refuses debug and fast programming flash accesses.
// - Only set-security command turns security on; nothing in software clears it.
// - Security clears only after wipe pin high and then a full erase.
// - With security clear, all interfaces may access flash again.
// - Two general-purpose bits set and cleared by commands, retained.
// - General-purpose bit 0 enables brownout detector; wipe clears it.
// - General-purpose bit 1 enables brownout reset; wipe clears it.
// - Eight factory calibration bits, fixed against software and wipe.
// - Test pin, straps zero and one high, strap two low: fast programming.
// - Fast programming accepts read, program, erases, lock, unlock, protect.
// - Test pin with all three straps high restores boot program.
// - Report last reset cause: power-up, software, user, watchdog, brownout.
// - Drive internal resets and shaped open-drain external reset pulse.
// - Enabled brownout detector output asserts at once, releases on recovery.
// - Registers decode inside top 4 KB starting at 0xFFFFF000.
`include "fnb_defines.svh"
module fnb_top
   import fnb_pkg::*;
#(
   parameter int LOCK_BITS = 8,
   parameter int REGION_PAGES = 32,
   parameter int PAGE_BYTES = 128,
   parameter int WIPE_CYCLES = `FNB_WIPE_CYC,
   parameter logic [7:0] CAL_BITS = 8'hA5 // Arbitrary factory value
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // AXI4-Lite slave
   input wire logic [31:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [31:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Strap and wipe pins
   input wire logic TEST_MODE_PIN,
   input wire logic STRAP_PIN_ZERO,
   input wire logic STRAP_PIN_ONE,
   input wire logic STRAP_PIN_TWO,
   input wire logic WIPE_PIN,
   // Outside flash access requests and grants
   input wire fnb_ext_req_t EXT_REQ,
   output logic DBG_GRANT,
   output logic FPP_GRANT,
   // Flash array command and completion
   output fnb_flash_cmd_t FLASH_CMD,
   input wire logic FLASH_DONE,
   output logic BOOT_RESTORE,
   // Brownout and reset
   input wire logic CORE_SUPPLY_LOW,
   input wire logic POWER_ON_N,
   input wire logic WATCHDOG_FAULT,
   input wire logic EXT_RESET_PIN_I,
   output logic EXT_RESET_PIN_O,
   output logic EXT_RESET_PIN_OE,
   output logic BROWNOUT_OUT,
   output logic BOD_ENABLE,
   output logic BOD_RESET_EN,
   output logic PROC_RESET_N,
   output logic PERIPH_RESET_N,
   output logic [7:0] CAL_OUT,
   output logic LOCK_IRQ
);
   localparam int PAGE_W = $clog2(LOCK_BITS * REGION_PAGES);
   localparam int REG_W = $clog2(LOCK_BITS);
   localparam int PAGE_IN_W = $clog2(REGION_PAGES);
   localparam int WCNT_W = $clog2(WIPE_CYCLES + 1);

   // ---------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------
   logic aw_have_q, w_have_q;
   logic [31:0] aw_addr_q, w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   logic aw_hit, ar_hit;
   logic [11:0] wr_off;

   assign AWREADY = !aw_have_q && !BVALID;
   assign WREADY = !w_have_q && !BVALID;
   assign wr_go = aw_have_q && w_have_q;
   assign wr_off = aw_addr_q[11:0];
   assign aw_hit = (aw_addr_q & `FNB_SYS_MASK) == `FNB_SYS_BASE;
   assign ar_hit = (ARADDR & `FNB_SYS_MASK) == `FNB_SYS_BASE;

   // Capture address and data in either order
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= AWADDR;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_have_q <= 1'b1;
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         BVALID <= 1'b0;
         BRESP <= 2'h0;
      end else if (wr_go) begin
         BVALID <= 1'b1;
         BRESP <= aw_hit ? 2'h0 : 2'h3;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Command decode
   // ---------------------------------------------
   logic cmd_wr, cmd_ok, busy_q;
   fnb_op_t cmd_op;
   logic [9:0] cmd_arg;
   logic [PAGE_W-1:0] cmd_page;
   logic [REG_W-1:0] cmd_region;
   logic [LOCK_BITS-1:0] lock_q;
   logic cmd_locked;
   logic fast_mode, recover_mode;

   assign cmd_wr = wr_go && aw_hit && (wr_off == `FNB_OFF_CMD) && (&w_strb_q);
   assign cmd_op = fnb_op_t'(w_data_q[`FNB_CMD_OP_MSB:`FNB_CMD_OP_LSB]);
   assign cmd_arg = w_data_q[`FNB_CMD_ARG_MSB:`FNB_CMD_ARG_LSB];
   assign cmd_ok = cmd_wr && !busy_q
      && (w_data_q[`FNB_CMD_KEY_MSB:`FNB_CMD_KEY_LSB] == `FNB_CMD_KEY);
   assign cmd_page = cmd_arg[PAGE_W-1:0];
   assign cmd_region = cmd_page[PAGE_W-1:PAGE_IN_W];
   assign cmd_locked = lock_q[cmd_region];

   // ---------------------------------------------
   // Wipe pin qualification
   // ---------------------------------------------
   logic wipe_s1_q, wipe_s2_q, wipe_q, wipe_seen_q;
   logic [WCNT_W-1:0] wipe_cnt_q;

   // Two-stage synchroniser
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         wipe_s1_q <= 1'b0;
         wipe_s2_q <= 1'b0;
      end else begin
         wipe_s1_q <= WIPE_PIN;
         wipe_s2_q <= wipe_s1_q;
      end
   end

   // Stable-time counter, one wipe event per assertion
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         wipe_cnt_q <= '0;
         wipe_q <= 1'b0;
      end else if (!wipe_s2_q) begin
         wipe_cnt_q <= '0;
         wipe_q <= 1'b0;
      end else if (wipe_cnt_q != WCNT_W'(WIPE_CYCLES)) begin
         wipe_cnt_q <= wipe_cnt_q + 1'b1;
         wipe_q <= (wipe_cnt_q == WCNT_W'(WIPE_CYCLES - 1));
      end else begin
         wipe_q <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Flash command sequencing
   // ---------------------------------------------
   logic lockerr_q, cmderr_q, done_q, ferase_q;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         busy_q <= 1'b0;
         ferase_q <= 1'b0;
         FLASH_CMD <= '0;
      end else if (cmd_ok && (cmd_op == FNB_OP_PROG || cmd_op == FNB_OP_PERASE)
                   && !cmd_locked) begin
         busy_q <= 1'b1;
         ferase_q <= 1'b0;
         FLASH_CMD <= '{go: 1'b1, op: cmd_op, page: cmd_arg};
      end else if (cmd_ok && cmd_op == FNB_OP_FERASE && lock_q == '0) begin
         busy_q <= 1'b1;
         ferase_q <= 1'b1;
         FLASH_CMD <= '{go: 1'b1, op: cmd_op, page: 10'h000};
      end else begin
         FLASH_CMD.go <= 1'b0;
         if (busy_q && FLASH_DONE) begin
            busy_q <= 1'b0;
         end
      end
   end

   // Sticky status flags; new event wins over the read clear
   logic st_rd;
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         lockerr_q <= 1'b0;
         cmderr_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (cmd_ok && cmd_locked && (cmd_op == FNB_OP_PROG || cmd_op == FNB_OP_PERASE))
            lockerr_q <= 1'b1;
         else if (cmd_ok && cmd_op == FNB_OP_FERASE && lock_q != '0)
            lockerr_q <= 1'b1;
         else if (st_rd)
            lockerr_q <= 1'b0;
         if (cmd_wr && (busy_q || !cmd_ok))
            cmderr_q <= 1'b1;
         else if (st_rd)
            cmderr_q <= 1'b0;
         if (busy_q && FLASH_DONE)
            done_q <= 1'b1;
         else if (st_rd)
            done_q <= 1'b0;
      end
   end
   assign LOCK_IRQ = lockerr_q;

   // ---------------------------------------------
   // Non-volatile bits
   // ---------------------------------------------
   logic [1:0] gp_q;
   logic secure_q, wipe_seen_arm;

   // Lock bits per region
   genvar gi;
   generate
      for (gi = 0; gi < LOCK_BITS; gi++) begin : g_lock
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               lock_q[gi] <= 1'b0;
            end else if (wipe_q) begin
               lock_q[gi] <= 1'b0;
            end else if (cmd_ok && cmd_region == REG_W'(gi)) begin
               if (cmd_op == FNB_OP_SETLOCK)
                  lock_q[gi] <= 1'b1;
               else if (cmd_op == FNB_OP_CLRLOCK)
                  lock_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // General-purpose bits
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         gp_q <= 2'h0;
      end else if (wipe_q) begin
         gp_q <= 2'h0;
      end else if (cmd_ok && cmd_op == FNB_OP_SETGP) begin
         gp_q[cmd_arg[0]] <= 1'b1;
      end else if (cmd_ok && cmd_op == FNB_OP_CLRGP) begin
         gp_q[cmd_arg[0]] <= 1'b0;
      end
   end

   // Security bit: set by command only, cleared by wipe followed by full erase
   assign wipe_seen_arm = wipe_q;
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         secure_q <= 1'b0;
         wipe_seen_q <= 1'b0;
      end else begin
         if (cmd_ok && cmd_op == FNB_OP_SETSEC)
            secure_q <= 1'b1;
         else if (wipe_seen_q && ferase_q && busy_q && FLASH_DONE)
            secure_q <= 1'b0;
         // A wipe counts only if it follows the latest set-security command
         if (wipe_seen_arm)
            wipe_seen_q <= 1'b1;
         else if (cmd_ok && cmd_op == FNB_OP_SETSEC)
            wipe_seen_q <= 1'b0;
         else if (ferase_q && busy_q && FLASH_DONE)
            wipe_seen_q <= 1'b0;
      end
   end

   // Outside access gating
   assign DBG_GRANT = EXT_REQ.dbg_req && !secure_q;
   assign FPP_GRANT = EXT_REQ.fpp_req && !secure_q && fast_mode;

   // Brownout control and calibration
   assign BOD_ENABLE = gp_q[0];
   assign BOD_RESET_EN = gp_q[1];
   assign BROWNOUT_OUT = gp_q[0] && CORE_SUPPLY_LOW;
   assign CAL_OUT = CAL_BITS;

   // ---------------------------------------------
   // Strap modes
   // ---------------------------------------------
   assign fast_mode = TEST_MODE_PIN && STRAP_PIN_ZERO && STRAP_PIN_ONE
      && !STRAP_PIN_TWO;
   assign recover_mode = TEST_MODE_PIN && STRAP_PIN_ZERO && STRAP_PIN_ONE
      && STRAP_PIN_TWO;
   assign BOOT_RESTORE = recover_mode;

   // ---------------------------------------------
   // Reset controller
   // ---------------------------------------------
   logic [7:0] rstlen_q;
   fnb_cause_t cause_q;
   logic [23:0] pulse_q;
   logic por_seen_q, ext_s1_q, ext_s2_q, ext_busy;
   logic sw_rst, bo_rst;

   assign sw_rst = cmd_ok && cmd_op == FNB_OP_SWRST;
   assign bo_rst = BROWNOUT_OUT && gp_q[1];
   assign ext_busy = pulse_q != 24'h00_0000;

   // External reset pin sampling
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ext_s1_q <= 1'b1;
         ext_s2_q <= 1'b1;
      end else begin
         ext_s1_q <= EXT_RESET_PIN_I;
         ext_s2_q <= ext_s1_q;
      end
   end

   // Cause of last reset; power-up first after release
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         por_seen_q <= 1'b0;
         cause_q <= FNB_RC_POWERUP;
      end else begin
         por_seen_q <= 1'b1;
         if (!POWER_ON_N || !por_seen_q)
            cause_q <= FNB_RC_POWERUP;
         else if (bo_rst)
            cause_q <= FNB_RC_BROWNOUT;
         else if (WATCHDOG_FAULT)
            cause_q <= FNB_RC_WATCHDOG;
         else if (sw_rst)
            cause_q <= FNB_RC_SOFTWARE;
         else if (!ext_s2_q && !ext_busy)
            cause_q <= FNB_RC_USER;
      end
   end

   // Shaped external reset pulse
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         pulse_q <= 24'h00_0000;
         rstlen_q <= `FNB_RSTLEN_RST;
      end else begin
         if (wr_go && aw_hit && wr_off == `FNB_OFF_RSTCTRL && w_strb_q[0])
            rstlen_q <= w_data_q[7:0];
         if (sw_rst || WATCHDOG_FAULT || bo_rst || !POWER_ON_N)
            pulse_q <= {rstlen_q, 16'h0000} | 24'(`FNB_RSTPULSE_UNIT);
         else if (ext_busy)
            pulse_q <= pulse_q - 24'h00_0001;
      end
   end
   assign EXT_RESET_PIN_O = 1'b0;
   assign EXT_RESET_PIN_OE = ext_busy;
   assign PROC_RESET_N = !ext_busy && ext_s2_q;
   assign PERIPH_RESET_N = !ext_busy && ext_s2_q;

   // ---------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------
   logic [31:0] rd_val;
   assign ARREADY = !RVALID;
   assign st_rd = ARVALID && ARREADY && ar_hit && ARADDR[11:0] == `FNB_OFF_STATUS;

   // Read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      case (ARADDR[11:0])
         `FNB_OFF_STATUS: begin
            rd_val[`FNB_ST_DONE] = done_q;
            rd_val[`FNB_ST_LOCKERR] = lockerr_q;
            rd_val[`FNB_ST_SECURE] = secure_q;
            rd_val[`FNB_ST_FASTPROG] = fast_mode;
            rd_val[`FNB_ST_RECOVER] = recover_mode;
            rd_val[`FNB_ST_BROWNOUT] = BROWNOUT_OUT;
            rd_val[`FNB_ST_CMDERR] = cmderr_q;
            rd_val[`FNB_ST_DENIED] = busy_q;
         end
         `FNB_OFF_LOCK: rd_val[LOCK_BITS-1:0] = lock_q;
         `FNB_OFF_NVBIT: rd_val[15:0] = {CAL_BITS, 6'h00, gp_q};
         `FNB_OFF_RSTCAUSE: rd_val[2:0] = cause_q;
         `FNB_OFF_RSTCTRL: rd_val[7:0] = rstlen_q;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Read data register
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= 2'h0;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RDATA <= ar_hit ? rd_val : 32'h0000_0000;
         RRESP <= ar_hit ? 2'h0 : 2'h3;
      end else if (RREADY) begin
         RVALID <= 1'b0;
      end
   end
endmodule

/* File: verilog/fnb_defines.svh */
`ifndef FNB_DEFINES_SVH
`define FNB_DEFINES_SVH
// ---------------------------------------------
// Register byte offsets inside the 4 KB window
// ---------------------------------------------
`define FNB_SYS_BASE 32'hFFFF_F000
`define FNB_SYS_MASK 32'hFFFF_F000
`define FNB_OFF_CMD 12'h000
`define FNB_OFF_STATUS 12'h004
`define FNB_OFF_LOCK 12'h008
`define FNB_OFF_NVBIT 12'h00C
`define FNB_OFF_RSTCAUSE 12'h010
`define FNB_OFF_RSTCTRL 12'h014
// ---------------------------------------------
// Command register fields
// ---------------------------------------------
`define FNB_CMD_OP_LSB 0
`define FNB_CMD_OP_MSB 3
`define FNB_CMD_ARG_LSB 8
`define FNB_CMD_ARG_MSB 17
`define FNB_CMD_KEY_LSB 24
`define FNB_CMD_KEY_MSB 31
`define FNB_CMD_KEY 8'h5A
// ---------------------------------------------
// Status register fields
// ---------------------------------------------
`define FNB_ST_DONE 0
`define FNB_ST_LOCKERR 1
`define FNB_ST_SECURE 2
`define FNB_ST_FASTPROG 3
`define FNB_ST_RECOVER 4
`define FNB_ST_BROWNOUT 5
`define FNB_ST_CMDERR 6
`define FNB_ST_DENIED 7
// ---------------------------------------------
// Reset values and timing
// ---------------------------------------------
`define FNB_CLK_MHZ 100
`define FNB_WIPE_MS 50
`define FNB_WIPE_CYC (`FNB_WIPE_MS * 1000 * `FNB_CLK_MHZ)
`define FNB_RSTLEN_RST 8'h01
`define FNB_RSTPULSE_UNIT 16'h0100
`endif

/* File: verilog/fnb_pkg.sv */
package fnb_pkg;
   // Flash commands
   typedef enum logic [3:0] {
      FNB_OP_NONE = 4'h0, FNB_OP_PROG = 4'h1, FNB_OP_PERASE = 4'h2,
      FNB_OP_FERASE = 4'h3, FNB_OP_SETLOCK = 4'h4, FNB_OP_CLRLOCK = 4'h5,
      FNB_OP_SETGP = 4'h6, FNB_OP_CLRGP = 4'h7, FNB_OP_SETSEC = 4'h8,
      FNB_OP_SWRST = 4'h9
   } fnb_op_t;
   // Reset causes
   typedef enum logic [2:0] {
      FNB_RC_POWERUP = 3'h0, FNB_RC_SOFTWARE = 3'h1, FNB_RC_USER = 3'h2,
      FNB_RC_WATCHDOG = 3'h3, FNB_RC_BROWNOUT = 3'h4
   } fnb_cause_t;
   // Access request from debug or fast programming port
   typedef struct packed {
      logic dbg_req;
      logic fpp_req;
   } fnb_ext_req_t;
   // Request to the flash array
   typedef struct packed {
      logic go;
      fnb_op_t op;
      logic [9:0] page;
   } fnb_flash_cmd_t;
endpackage

/* File: verification/fnb_prog_model.sv */
`timescale 1ns/1ps
module fnb_prog_model #(
   parameter int HOLD = 40
) (
   // Clock and commands from the bench
   input wire logic clk,
   input wire logic [3:0] strap_sel,
   input wire logic wipe_go,
   // Pins toward the device
   output logic test_pin,
   output logic strap_zero,
   output logic strap_one,
   output logic strap_two,
   output logic wipe_pin
);
   int hold_cnt = 0;
   // Strap levels are held as static pin levels
   assign {test_pin, strap_zero, strap_one, strap_two} = strap_sel;
   // Wipe pulse is always held past the qualifying time
   always_ff @(posedge clk) begin
      if (wipe_go) begin
         hold_cnt <= HOLD;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end
   end
   // Released pin falls to its pull-down level
   assign wipe_pin = (hold_cnt > 0);
endmodule

/* File: verification/fnb_top_asserts.sv */
`timescale 1ns/1ps
module fnb_top_asserts
   import fnb_pkg::*;
#(
   parameter int WIPE_CYCLES = 20,
   parameter logic [7:0] CAL_BITS = 8'hA5
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Read channel
   input wire logic [31:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   // Pins and status outputs
   input wire logic TEST_MODE_PIN,
   input wire logic STRAP_PIN_ZERO,
   input wire logic STRAP_PIN_ONE,
   input wire logic STRAP_PIN_TWO,
   input wire logic WIPE_PIN,
   input wire logic FPP_GRANT,
   input wire fnb_flash_cmd_t FLASH_CMD,
   input wire logic BOOT_RESTORE,
   input wire logic CORE_SUPPLY_LOW,
   input wire logic EXT_RESET_PIN_O,
   input wire logic EXT_RESET_PIN_OE,
   input wire logic BROWNOUT_OUT,
   input wire logic BOD_ENABLE,
   input wire logic BOD_RESET_EN,
   input wire logic [7:0] CAL_OUT
);
   logic [31:0] wipe_run_q;
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   // Counts consecutive cycles of wipe pin high
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || !WIPE_PIN) begin
         wipe_run_q <= 32'h0;
      end else if (wipe_run_q != 32'hFFFFFFFF) begin
         wipe_run_q <= wipe_run_q + 32'h1;
      end
   end
   // ------------------------------
   // Properties
   // ------------------------------
   chk_boot_straps: assert property (
      BOOT_RESTORE == (TEST_MODE_PIN && STRAP_PIN_ZERO && STRAP_PIN_ONE && STRAP_PIN_TWO))
      else $error("boot restore does not follow straps");
   chk_fast_straps: assert property (
      FPP_GRANT |-> TEST_MODE_PIN && STRAP_PIN_ZERO && STRAP_PIN_ONE && !STRAP_PIN_TWO)
      else $error("fast port granted outside fast mode");
   chk_bod_output: assert property (
      BROWNOUT_OUT == (BOD_ENABLE && CORE_SUPPLY_LOW))
      else $error("brownout output wrong");
   chk_cal_fixed: assert property (CAL_OUT == CAL_BITS)
      else $error("calibration bits changed");
   chk_wipe_filter: assert property (
      $rose(WIPE_PIN) && BOD_ENABLE |=> BOD_ENABLE [*8])
      else $error("short wipe acted on");
   chk_wipe_clears: assert property (
      wipe_run_q == WIPE_CYCLES + 6 |-> !BOD_ENABLE && !BOD_RESET_EN)
      else $error("qualified wipe left bits set");
   chk_go_single: assert property (FLASH_CMD.go |=> !FLASH_CMD.go)
      else $error("flash start longer than one cycle");
   chk_pin_drain: assert property (EXT_RESET_PIN_OE |-> !EXT_RESET_PIN_O)
      else $error("reset pin driven high");
   chk_outside_err: assert property (
      ARVALID && ARREADY && ARADDR[31:12] != 20'hFFFFF |=> RVALID && RRESP == 2'h3)
      else $error("outside address not refused");
endmodule
bind fnb_top fnb_top_asserts #(.WIPE_CYCLES(WIPE_CYCLES), .CAL_BITS(CAL_BITS)) u_asserts (.*);

/* File: verification/test_flash_nvm_bit_protection.sv */
`timescale 1ns/1ps
`include "fnb_defines.svh"
module test_flash_nvm_bit_protection
   import fnb_pkg::*;
();
   typedef struct packed {logic [3:0] sel; logic boot; logic fpp;} fnb_row_t;
   localparam logic [7:0] CAL = 8'h3C; // Arbitrary factory value
   localparam logic [31:0] A_CMD = {20'hFFFFF, `FNB_OFF_CMD};
   localparam logic [31:0] A_STAT = {20'hFFFFF, `FNB_OFF_STATUS};
   localparam logic [31:0] A_LOCK = {20'hFFFFF, `FNB_OFF_LOCK};
   localparam logic [31:0] A_NV = {20'hFFFFF, `FNB_OFF_NVBIT};
   localparam logic [31:0] A_CAUSE = {20'hFFFFF, `FNB_OFF_RSTCAUSE};
   logic CORE_CLK = 1'b0, RST_N = 1'b0, POWER_ON_N = 1'b0, WATCHDOG_FAULT = 1'b0;
   logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA, rdata, st;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DBG_GRANT, FPP_GRANT, BOOT_RESTORE;
   logic [1:0] BRESP, RRESP, rresp;
   logic [3:0] strap_sel = 4'h0, WSTRB = 4'hF;
   logic wipe_go = 1'b0, FLASH_DONE = 1'b0, CORE_SUPPLY_LOW = 1'b0;
   logic TEST_MODE_PIN, STRAP_PIN_ZERO, STRAP_PIN_ONE, STRAP_PIN_TWO, WIPE_PIN;
   logic EXT_RESET_PIN_O, EXT_RESET_PIN_OE, BROWNOUT_OUT, BOD_ENABLE, BOD_RESET_EN;
   logic PROC_RESET_N, PERIPH_RESET_N, LOCK_IRQ;
   logic [7:0] CAL_OUT;
   fnb_ext_req_t EXT_REQ = '0;
   fnb_flash_cmd_t FLASH_CMD, last_cmd;
   int fail_count = 0, checked = 0, go_count = 0, irq_cnt = 0, g, i;
   fnb_row_t rows [5] = '{'{4'hE, 1'b0, 1'b1}, '{4'hF, 1'b1, 1'b0}, '{4'h6, 1'b0, 1'b0},
      '{4'hC, 1'b0, 1'b0}, '{4'hA, 1'b0, 1'b0}};
   // Open-drain reset wire with pull-up
   wire logic EXT_RESET_PIN_I = EXT_RESET_PIN_OE ? EXT_RESET_PIN_O : 1'b1;
   always #5 CORE_CLK = ~CORE_CLK;
   // ------------------------------
   // Design, programmer and flash array
   // ------------------------------
   fnb_top #(.WIPE_CYCLES(20), .CAL_BITS(CAL)) uut (.*);
   fnb_prog_model #(.HOLD(40)) u_prog (.clk(CORE_CLK), .strap_sel(strap_sel),
      .wipe_go(wipe_go), .test_pin(TEST_MODE_PIN), .strap_zero(STRAP_PIN_ZERO),
      .strap_one(STRAP_PIN_ONE), .strap_two(STRAP_PIN_TWO), .wipe_pin(WIPE_PIN));
   // Flash array finishes each started operation one cycle later
   always @(posedge CORE_CLK) begin
      FLASH_DONE <= (FLASH_CMD.go === 1'b1);
      if (FLASH_CMD.go === 1'b1) begin
         go_count <= go_count + 1;
         last_cmd <= FLASH_CMD;
      end
      if (LOCK_IRQ === 1'b1) irq_cnt <= irq_cnt + 1;
   end
   // ------------------------------
   // Bus and compare tasks
   // ------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         n++;
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
      end while (!(BVALID && BREADY) && n < 50);
      BREADY <= 1'b0;
   endtask
   task automatic axr(input logic [31:0] a);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         n++;
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
      end while (!(RVALID && RREADY) && n < 50);
      rdata = RDATA;
      rresp = RRESP;
      RREADY <= 1'b0;
   endtask
   // Issues a command and polls status until it ends
   task automatic cmd(input logic [7:0] key, input fnb_op_t op, input logic [9:0] arg);
      int n;
      n = 0;
      axw(A_CMD, {key, 6'h00, arg, 4'h0, op});
      do begin
         axr(A_STAT);
         n++;
      end while (rdata[0] !== 1'b1 && rdata[1] !== 1'b1 && rdata[6] !== 1'b1 && n < 40);
      st = rdata;
   endtask
   task automatic wipe();
      @(posedge CORE_CLK);
      wipe_go <= 1'b1;
      @(posedge CORE_CLK);
      wipe_go <= 1'b0;
      repeat (50) @(posedge CORE_CLK);
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog against a hung run
   initial begin
      #300000;
      fail_count++;
      tally_and_finish();
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (4) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      POWER_ON_N <= 1'b1;
      axr(A_LOCK);
      check(rdata, 32'h0);
      axr(A_NV);
      check(rdata, {16'h0, CAL, 8'h00});
      axr(A_CAUSE);
      check(rdata, {29'h0, FNB_RC_POWERUP});
      foreach (rows[k]) begin
         @(posedge CORE_CLK);
         strap_sel <= rows[k].sel;
         EXT_REQ <= 2'b11;
         @(posedge CORE_CLK);
         #1;
         chk1(BOOT_RESTORE, rows[k].boot);
         chk1(FPP_GRANT, rows[k].fpp);
         chk1(DBG_GRANT, 1'b1);
         axr(A_STAT);
         check({30'h0, rdata[4:3]}, {30'h0, rows[k].boot, rows[k].fpp});
      end
      strap_sel <= 4'h0;
      // Locked region refuses program and erase at region boundaries
      cmd(`FNB_CMD_KEY, FNB_OP_SETLOCK, 10'd33);
      axr(A_LOCK);
      check(rdata, 32'h2);
      g = go_count;
      i = irq_cnt;
      cmd(`FNB_CMD_KEY, FNB_OP_PROG, 10'd63);
      chk1(st[1], 1'b1);
      chk1(irq_cnt > i, 1'b1);
      cmd(`FNB_CMD_KEY, FNB_OP_PERASE, 10'd32);
      chk1(st[1], 1'b1);
      cmd(`FNB_CMD_KEY, FNB_OP_FERASE, 10'd0);
      check(go_count - g, 0);
      chk1(LOCK_IRQ, 1'b0);
      cmd(`FNB_CMD_KEY, FNB_OP_PROG, 10'd64);
      check(go_count - g, 1);
      check({22'h0, last_cmd.page}, 32'd64);
      cmd(`FNB_CMD_KEY, FNB_OP_CLRLOCK, 10'd32);
      axr(A_LOCK);
      check(rdata, 32'h0);
      cmd(8'h00, FNB_OP_SETLOCK, 10'd0);
      chk1(st[6], 1'b1);
      // Addresses outside and inside the system window
      axr(32'h0000_1000);
      check({rresp, rdata[29:0]}, 32'hC000_0000);
      axr(32'hFFFF_F0F0);
      check({rresp, rdata[29:0]}, 32'h0000_0000);
      // General-purpose bits, brownout and wipe
      cmd(`FNB_CMD_KEY, FNB_OP_SETGP, 10'd0);
      chk1(BOD_ENABLE, 1'b1);
      CORE_SUPPLY_LOW <= 1'b1;
      @(posedge CORE_CLK);
      #1;
      chk1(BROWNOUT_OUT, 1'b1);
      @(posedge CORE_CLK);
      CORE_SUPPLY_LOW <= 1'b0;
      @(posedge CORE_CLK);
      #1;
      chk1(BROWNOUT_OUT, 1'b0);
      cmd(`FNB_CMD_KEY, FNB_OP_SETGP, 10'd1);
      chk1(BOD_RESET_EN, 1'b1);
      cmd(`FNB_CMD_KEY, FNB_OP_SETLOCK, 10'd255);
      axr(A_NV);
      check(rdata, {16'h0, CAL, 8'h03});
      wipe();
      axr(A_LOCK);
      check(rdata, 32'h0);
      axr(A_NV);
      check(rdata, {16'h0, CAL, 8'h00});
      // Security set, survives a plain erase, cleared by wipe then erase
      strap_sel <= 4'hE;
      cmd(`FNB_CMD_KEY, FNB_OP_SETSEC, 10'd0);
      chk1(st[2], 1'b1);
      chk1(DBG_GRANT, 1'b0);
      chk1(FPP_GRANT, 1'b0);
      cmd(`FNB_CMD_KEY, FNB_OP_FERASE, 10'd0);
      chk1(st[2], 1'b1);
      wipe();
      cmd(`FNB_CMD_KEY, FNB_OP_FERASE, 10'd0);
      chk1(st[2], 1'b0);
      chk1(DBG_GRANT, 1'b1);
      chk1(FPP_GRANT, 1'b1);
      // Reset causes and reset pin pulse
      WATCHDOG_FAULT <= 1'b1;
      @(posedge CORE_CLK);
      WATCHDOG_FAULT <= 1'b0;
      axr(A_CAUSE);
      check(rdata, {29'h0, FNB_RC_WATCHDOG});
      cmd(`FNB_CMD_KEY, FNB_OP_SWRST, 10'd0);
      chk1(EXT_RESET_PIN_OE, 1'b1);
      tally_and_finish();
   end
endmodule
